// ==== shared/gctl_defs.svh ====
/*
 * Constants of the global control register bank: offsets, reset values,
 * field positions and the value that unlisted addresses read.
 * Assumes a serial port front end that delivers whole register accesses.
 */
// Functional notes
// - A write to an unlisted address changes no state at all.
// - Soft reset control sits in bit 0 at address zero, default zero.
// - Reference path enable field is bits 3..0 of mode register, default 4f.
// - Each input buffer register: enable in bit 0, mode above, default 07.
// - Loss validation timer is bits 2..0, default 03.
`ifndef GCTL_DEFS_SVH
`define GCTL_DEFS_SVH

`define GCTL_ADDR_W 13
`define GCTL_NREGS 18

// Offsets
`define GCTL_OFF_SOFT_RESET 13'h0000
`define GCTL_OFF_REQ_MODE 13'h0001
`define GCTL_OFF_TUNE_SLIP 13'h0002
`define GCTL_OFF_LOOP_EN 13'h0003
`define GCTL_OFF_OUT_PAIR 13'h0004
`define GCTL_OFF_MODE_PATH 13'h0005
`define GCTL_OFF_ALARM_CLR 13'h0006
`define GCTL_OFF_SCRATCH_A 13'h0007
`define GCTL_OFF_SCRATCH_B 13'h0008
`define GCTL_OFF_LOCK_ALIGN 13'h0009
`define GCTL_OFF_BUF_FIRST 13'h000a
`define GCTL_OFF_BUF_LAST 13'h000e
`define GCTL_OFF_PRIORITY 13'h0014
`define GCTL_OFF_SIG_LOSS 13'h0015
`define GCTL_OFF_HOLD_EXIT 13'h0016
// Index of the first register of the upper group
`define GCTL_IDX_UPPER 5'h0f

// Reset values
`define GCTL_DEF_SOFT_RESET 8'h00
`define GCTL_DEF_REQ_MODE 8'h00
`define GCTL_DEF_TUNE_SLIP 8'h00
`define GCTL_DEF_LOOP_EN 8'h37
`define GCTL_DEF_OUT_PAIR 8'h7f
`define GCTL_DEF_MODE_PATH 8'h4f
`define GCTL_DEF_ALARM_CLR 8'h00
`define GCTL_DEF_SCRATCH 8'h00
`define GCTL_DEF_LOCK_ALIGN 8'h01
`define GCTL_DEF_BUF 8'h07
`define GCTL_DEF_PRIORITY 8'he4
`define GCTL_DEF_SIG_LOSS 8'h03
`define GCTL_DEF_HOLD_EXIT 8'h0c
`define GCTL_UNMAPPED_READ 8'h00

// Field positions
`define GCTL_SOFT_RESET_BIT 0
`define GCTL_OUT_PAIR_MSB 6
`define GCTL_PATH_EN_MSB 3
`define GCTL_BUF_EN_BIT 0
`define GCTL_BUF_MODE_MSB 4
`define GCTL_BUF_MODE_LSB 1
`define GCTL_LOS_TIMER_MSB 2

`endif

// ==== shared/gctl_pkg.sv ====
/*
 * Types of the global control register bank.
 * Assumes gctl_defs.svh is on the include path.
 */
`include "gctl_defs.svh"

package gctl_pkg;

    typedef logic [`GCTL_ADDR_W-1:0] gctl_addr_t;
    typedef logic [7:0] gctl_byte_t;

    // One whole register access from the serial port front end
    typedef struct packed {
        logic wr;
        logic rd;
        gctl_addr_t addr;
        gctl_byte_t data;
    } gctl_req_s;

    // Decoded configuration seen by the rest of the device
    typedef struct packed {
        logic soft_reset;
        gctl_byte_t req_mode;
        gctl_byte_t tune_slip;
        gctl_byte_t loop_en;
        logic [6:0] out_pair_en;
        logic [3:0] ref_path_en;
        logic [3:0] mode_path_hi;
        gctl_byte_t alarm_clr;
        gctl_byte_t lock_align;
        logic [4:0] buf_en;
        logic [4:0][3:0] buf_mode;
        gctl_byte_t ref_priority;
        logic [2:0] los_timer;
        gctl_byte_t hold_exit;
    } gctl_cfg_s;

endpackage

// ==== hw/gctl_regs.sv ====
/*
 * Global control and reference loop input register bank.
 * Assumes the serial port front end hands over one access per request,
 * synchronous to ref_clk, writes on the final data edge of the frame.
 */
`timescale 1ns/1ps
`include "gctl_defs.svh"

module gctl_regs #(
    parameter int NREGS = `GCTL_NREGS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Register access
    input wire gctl_pkg::gctl_req_s req,
    output logic rd_valid,
    output gctl_pkg::gctl_byte_t rd_data_ff,
    // Configuration
    output gctl_pkg::gctl_cfg_s cfg
);

    // Decode and default tables cover exactly the listed register set
    if (NREGS != `GCTL_NREGS) begin : g_nregs_check
        $error("gctl_regs serves exactly the listed register set");
    end

    ////////////////////////////////////////////////////////////////////////
    // Address map

    function automatic logic [5:0] map_addr(input gctl_pkg::gctl_addr_t a);
        logic [5:0] r;
        r = 6'h00;
        if (a <= `GCTL_OFF_BUF_LAST) begin
            r = {1'b1, a[4:0]};
        end else if (a >= `GCTL_OFF_PRIORITY && a <= `GCTL_OFF_HOLD_EXIT) begin
            r = {1'b1, 5'(a[4:0] - `GCTL_OFF_PRIORITY + `GCTL_IDX_UPPER)};
        end
        return r;
    endfunction

    function automatic gctl_pkg::gctl_byte_t def_of(input logic [4:0] i);
        gctl_pkg::gctl_byte_t d;
        d = `GCTL_DEF_SCRATCH;
        unique case (i)
            5'h00: d = `GCTL_DEF_SOFT_RESET;
            5'h01: d = `GCTL_DEF_REQ_MODE;
            5'h02: d = `GCTL_DEF_TUNE_SLIP;
            5'h03: d = `GCTL_DEF_LOOP_EN;
            5'h04: d = `GCTL_DEF_OUT_PAIR;
            5'h05: d = `GCTL_DEF_MODE_PATH;
            5'h06: d = `GCTL_DEF_ALARM_CLR;
            5'h09: d = `GCTL_DEF_LOCK_ALIGN;
            5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e: d = `GCTL_DEF_BUF;
            5'h0f: d = `GCTL_DEF_PRIORITY;
            5'h10: d = `GCTL_DEF_SIG_LOSS;
            5'h11: d = `GCTL_DEF_HOLD_EXIT;
            default: d = `GCTL_DEF_SCRATCH;
        endcase
        return d;
    endfunction

    logic [5:0] wr_map;
    logic [5:0] rd_map;
    logic wr_hit;
    logic soft_hit;
    logic [NREGS-1:0][7:0] regs_ff;
    logic [NREGS-1:0][7:0] def_image;

    assign wr_map = map_addr(req.addr);
    assign rd_map = wr_map;
    assign wr_hit = req.wr && wr_map[5];
    // Soft reset is a one-shot: writing the bit restores every default,
    // the bit itself included, so it always reads back zero.
    assign soft_hit = wr_hit && (req.addr == `GCTL_OFF_SOFT_RESET) &&
                      req.data[`GCTL_SOFT_RESET_BIT];

    always_comb begin
        for (int i = 0; i < NREGS; i++) begin
            def_image[i] = def_of(5'(i));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_ff[i] <= def_of(5'(i));
            end
        end else if (soft_hit) begin
            regs_ff <= def_image;
        end else if (wr_hit) begin
            // Unlisted addresses never reach here
            regs_ff[wr_map[4:0]] <= req.data;
        end
    end

    // Read answer one cycle after the request; holes read zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_data_ff <= `GCTL_UNMAPPED_READ;
        end else if (req.rd) begin
            rd_data_ff <= rd_map[5] ? regs_ff[rd_map[4:0]] :
                          `GCTL_UNMAPPED_READ;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= req.rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded fields

    always_comb begin
        cfg = '0;
        cfg.soft_reset = soft_hit;
        cfg.req_mode = regs_ff[1];
        cfg.tune_slip = regs_ff[2];
        cfg.loop_en = regs_ff[3];
        cfg.out_pair_en = regs_ff[4][`GCTL_OUT_PAIR_MSB:0];
        cfg.ref_path_en = regs_ff[5][`GCTL_PATH_EN_MSB:0];
        cfg.mode_path_hi = regs_ff[5][7:4];
        cfg.alarm_clr = regs_ff[6];
        cfg.lock_align = regs_ff[9];
        for (int b = 0; b < 5; b++) begin
            cfg.buf_en[b] = regs_ff[10+b][`GCTL_BUF_EN_BIT];
            cfg.buf_mode[b] =
                regs_ff[10+b][`GCTL_BUF_MODE_MSB:`GCTL_BUF_MODE_LSB];
        end
        cfg.ref_priority = regs_ff[15];
        cfg.los_timer = regs_ff[16][`GCTL_LOS_TIMER_MSB:0];
        cfg.hold_exit = regs_ff[17];
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Write, one quiet cycle, then a read of the same address: the pace
    // of a host that releases the request between accesses
    sequence plain_write_s;
        req.wr && wr_map[5] && !soft_hit && !req.rd;
    endsequence

    sequence readback_s;
        req.rd && !req.wr && (req.addr == $past(req.addr, 2));
    endsequence

    sequence hole_read_s;
        req.rd && !rd_map[5];
    endsequence

    unmapped_write_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wr && !wr_map[5]) |=> $stable(regs_ff))
        else $error("write to unlisted address changed state");

    hole_read_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        hole_read_s |=> rd_valid && rd_data_ff == `GCTL_UNMAPPED_READ)
        else $error("read of unlisted address returned data");

    soft_reset_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        soft_hit |=> (regs_ff == def_image) && (regs_ff[0] == 8'h00))
        else $error("soft reset did not restore defaults");

    pair_enable_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wr && req.addr == `GCTL_OFF_OUT_PAIR) |=>
        cfg.out_pair_en == $past(req.data[6:0]))
        else $error("output pair enables not taken from low bits");

    path_enable_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wr && req.addr == `GCTL_OFF_MODE_PATH) |=>
        cfg.ref_path_en == $past(req.data[3:0]))
        else $error("reference path enable field misplaced");

    buffer_fields_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wr && req.addr == `GCTL_OFF_BUF_FIRST) |=>
        cfg.buf_en[0] == $past(req.data[0]) &&
        cfg.buf_mode[0] == $past(req.data[4:1]))
        else $error("input buffer fields misplaced");

    osc_buffer_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wr && req.addr == `GCTL_OFF_BUF_LAST) |=>
        cfg.buf_en[4] == $past(req.data[0]) &&
        cfg.buf_mode[4] == $past(req.data[4:1]))
        else $error("oscillator buffer fields misplaced");

    los_timer_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        (req.wr && req.addr == `GCTL_OFF_SIG_LOSS) |=>
        cfg.los_timer == $past(req.data[2:0]))
        else $error("loss validation timer misplaced");

    read_back_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        plain_write_s ##1 !req.wr ##1 readback_s |=>
        rd_valid && rd_data_ff == $past(req.data, 3))
        else $error("read did not return the value last stored");

    read_strobe_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        rd_valid == $past(req.rd))
        else $error("read answer strobe not one cycle after request");

    // Read data stands until the next read is taken
    read_hold_a: assert property (
        @(posedge ref_clk) disable iff (reset)
        !req.rd |=> $stable(rd_data_ff))
        else $error("read data changed without a read");

    reset_default_a: assert property (
        @(posedge ref_clk)
        $fell(reset) |-> regs_ff == def_image && rd_valid == 1'b0 &&
        rd_data_ff == `GCTL_UNMAPPED_READ)
        else $error("register image not at defaults after reset");

endmodule

// ==== bench/gctl_host_model.sv ====
/*
 * Host model: issues whole register accesses to the bank.
 * Assumes the bench calls wr and rd one at a time.
 */
`timescale 1ns/1ps

module gctl_host_model (
    // Clock
    input wire logic ref_clk,
    // Register access
    output gctl_pkg::gctl_req_s req,
    input wire logic rd_valid,
    input wire gctl_pkg::gctl_byte_t rd_data_ff
);
    initial req = '0;
    // Callers keep reserved bits at their defaults
    task automatic wr(input gctl_pkg::gctl_addr_t a,
                      input gctl_pkg::gctl_byte_t d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge ref_clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input gctl_pkg::gctl_addr_t a, output logic v,
                      output gctl_pkg::gctl_byte_t d);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1;
        v = rd_valid;
        d = rd_data_ff;
    endtask
endmodule

// ==== bench/clock_chip_global_control_regs_tb_top.sv ====
/*
 * Self-checking bench of the global control register bank.
 * Assumes the host model and the design package are compiled first.
 */
`timescale 1ns/1ps

module clock_chip_global_control_regs_tb_top;
    logic ref_clk;
    logic reset;
    gctl_pkg::gctl_req_s req;
    logic rd_valid;
    gctl_pkg::gctl_byte_t rd_data_ff;
    gctl_pkg::gctl_cfg_s cfg;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    logic [7:0] dft [18] = '{8'h00, 8'h00, 8'h00, 8'h37, 8'h7f, 8'h4f,
        8'h00, 8'h00, 8'h00, 8'h01, 8'h07, 8'h07, 8'h07, 8'h07, 8'h07,
        8'he4, 8'h03, 8'h0c};
    logic [7:0] cur [18];

    gctl_regs dut_u (.ref_clk(ref_clk), .reset(reset), .req(req),
        .rd_valid(rd_valid), .rd_data_ff(rd_data_ff), .cfg(cfg));
    gctl_host_model host_u (.ref_clk(ref_clk), .req(req),
        .rd_valid(rd_valid), .rd_data_ff(rd_data_ff));

    ////////////////////////////////////////////////////////////////////
    // Upper group starts at 0x14 after the gap
    function automatic logic [12:0] adr(input int i);
        return (i < 15) ? 13'(i) : 13'(i + 5);
    endfunction
    // Buffer register image rebuilt from the decoded fields
    function automatic logic [7:0] buf_of(input int b);
        return {3'h0, cfg.buf_mode[b], cfg.buf_en[b]};
    endfunction
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        logic v;
        logic [7:0] d;
        host_u.rd(a, v, d);
        chk("rd_valid", 8'h01, {7'h00, v});
        chk("rd_data", e, d);
    endtask
    task automatic all_chk();
        for (int i = 0; i < 18; i++) rd_chk(adr(i), cur[i]);
    endtask
    task automatic put(input int i, input logic [7:0] d);
        host_u.wr(adr(i), d);
        cur[i] = d;
    endtask
    task automatic t_defaults();
        cur = dft;
        all_chk();
        chk("out_pair", 8'h7f, {1'b0, cfg.out_pair_en});
        chk("path_en", 8'h0f, {4'h0, cfg.ref_path_en});
        chk("los_timer", 8'h03, {5'h00, cfg.los_timer});
        chk("loop_en", 8'h37, cfg.loop_en);
        chk("lock_align", 8'h01, cfg.lock_align);
        chk("priority", 8'he4, cfg.ref_priority);
        chk("hold_exit", 8'h0c, cfg.hold_exit);
        for (int b = 0; b < 5; b++) begin
            chk("buf", 8'h07, buf_of(b));
        end
    endtask
    task automatic t_fields();
        put(4, 8'h15);
        chk("out_pair", 8'h15, {1'b0, cfg.out_pair_en});
        put(5, 8'h4a);
        chk("path_en", 8'h0a, {4'h0, cfg.ref_path_en});
        chk("mode_hi", 8'h04, {4'h0, cfg.mode_path_hi});
        put(16, 8'h05);
        chk("los_timer", 8'h05, {5'h00, cfg.los_timer});
        put(7, 8'ha5);
        rd_chk(adr(7), 8'ha5);
        for (int b = 0; b < 5; b++) begin
            put(10 + b, 8'((b + 9) * 2 + b % 2));
            chk("buf", cur[10 + b], buf_of(b));
        end
        all_chk();
    endtask
    task automatic t_unmapped();
        logic [12:0] bad [4] = '{13'h000f, 13'h0013, 13'h0017, 13'h1fff};
        for (int k = 0; k < 4; k++) begin
            host_u.wr(bad[k], 8'hff);
            rd_chk(bad[k], 8'h00);
        end
        all_chk();
    endtask
    task automatic t_resets();
        fork
            host_u.wr(13'h0000, 8'h01);
            begin
                @(posedge ref_clk);
                #1;
                chk("soft_reset", 8'h01, {7'h00, cfg.soft_reset});
            end
        join
        cur = dft;
        all_chk();
        chk("out_pair", 8'h7f, {1'b0, cfg.out_pair_en});
        put(8, 8'h3c);
        @(posedge ref_clk);
        reset <= 1'b1;
        @(posedge ref_clk);
        reset <= 1'b0;
        cur = dft;
        all_chk();
    endtask
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Whole run needs about 230 cycles; the ceiling leaves a wide margin
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        reset = 1'b1;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_defaults();
        t_fields();
        t_unmapped();
        t_resets();
        tally_and_finish();
    end
endmodule
